// ### scp_pkg.sv
/*
 * shared constants and helpers of the smart card serial port, plus the
 * card clock generator that runs on the link clock.
 * assumes the link clock runs at twice the base clock (744 x bit rate).
 */
//
// Contract
// - parity-failed character still loads receive data
// - receive-full flag with enable requests receive irq
// - overrun, parity, error-signal flags request error irq
// - transmit end flag with enable requests transmit irq
// - transmit-done irq never raised in card mode
// - base clock is 372 times bit rate
// - start edge sampled on base clock aligns timing
// - bits latched on 186th base clock pulse
// - parity mismatch sets parity error flag automatically
// - parity-failed character leaves receive-full unchanged
// - good parity sets receive-full, raises receive irq
// - good character: data line released in error slot
// - card error signal sets flag, error irq
// - errored transmit: no end flag, retransmit
// - no error signal: set transmit end flag
// - fix mode holds card clock at chosen level
// - clock stop completes current cycle, then holds
// - clock restart begins with normal duty cycle
// - character mode only, no block transfer
// - bit order and invert select convention
// - card clock runs at 372 times bit rate
package scp_pkg;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int unsigned BASE_DIV      = 372;
   localparam int unsigned CNT_W         = 9;
   localparam logic [8:0]  CNT_LAST      = 9'(BASE_DIV - 1);
   localparam logic [8:0]  CNT_SAMPLE    = 9'h0_0B9;
   localparam int unsigned IDX_W         = 4;
   localparam logic [3:0]  BIT_START     = 4'h0;
   localparam logic [3:0]  BIT_PARITY    = 4'h9;
   localparam logic [3:0]  BIT_ERR_SLOT  = 4'hA;
   localparam logic [3:0]  BIT_ERR_CHECK = 4'hB;
   localparam logic [3:0]  BIT_RETRY_END = 4'hC;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic        TX_EMPTY_RST  = 1'b1;
   localparam logic        TX_END_RST    = 1'b1;
   localparam logic [7:0]  RX_DATA_RST   = 8'h00;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // same mapping both ways: reverse for msb-first, then invert
   function automatic logic [7:0] map_bits(input logic [7:0] d,
                                           input logic       msbFirst,
                                           input logic       invert);
      logic [7:0] r;
      r = d;
      if (msbFirst) begin
         for (int i = 0; i < 8; i++) begin
            r[i] = d[7 - i];
         end
      end
      return invert ? ~r : r;
   endfunction

   function automatic logic line_parity(input logic [7:0] lineBits,
                                        input logic       odd);
      return (^lineBits) ^ odd;
   endfunction

endpackage

module scp_card_clock (
   input  wire logic linkClk,
   input  wire logic linkRstn,
   input  wire logic runReq,
   input  wire logic fixMode,
   input  wire logic holdLevel,
   output logic      baseTick,
   output logic      cardClk
);
   import scp_pkg::*;

   logic phase_q;
   logic run_q;

   always_ff @(posedge linkClk or negedge linkRstn) begin
      if (!linkRstn) begin
         phase_q <= 1'b0;
      end else begin
         phase_q <= ~phase_q;
      end
   end

   // run only changes on a cycle boundary so no pulse is clipped
   always_ff @(posedge linkClk or negedge linkRstn) begin
      if (!linkRstn) begin
         run_q <= 1'b0;
      end else if (phase_q) begin
         run_q <= runReq;
      end
   end

   always_ff @(posedge linkClk or negedge linkRstn) begin
      if (!linkRstn) begin
         cardClk  <= 1'b0;
         baseTick <= 1'b0;
      end else begin
         baseTick <= ~phase_q;
         if (phase_q ? runReq : run_q) begin
            cardClk <= ~phase_q;
         end else begin
            cardClk <= fixMode & holdLevel;
         end
      end
   end

endmodule

// ### scp_serial_port.sv
/*
 * smart card serial port, t=0 character mode: receive and transmit
 * engines with error signal and retransmission, status flags and
 * interrupt requests.
 * assumes: control bits are static clk-domain levels while a frame
 * runs; linkClk is free running at twice the base clock.
 */
module scp_serial_port (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic linkClk,
   input  wire logic cardModeEnable,
   input  wire logic rxEnBit,
   input  wire logic txEnBit,
   input  wire logic rxIrqEnable,
   input  wire logic txIrqEnable,
   input  wire logic bitOrderBit,
   input  wire logic dataInvertBit,
   input  wire logic oddParity,
   input  wire logic clockFixMode,
   input  wire logic clockLevelSelect,
   input  wire logic clockOutputEnable,
   input  wire logic [7:0] txData,
   input  wire logic txWrite,
   input  wire logic clrRxFull,
   input  wire logic clrParityErr,
   input  wire logic clrOverrun,
   input  wire logic clrErrSignal,
   input  wire logic dataIn,
   output logic [7:0] rxData,
   output logic      rxFullFlag,
   output logic      parityErrFlag,
   output logic      overrunErrorFlag,
   output logic      errorSignalFlag,
   output logic      txEndFlag,
   output logic      txEmptyFlag,
   output logic      rxFullIrq,
   output logic      txEmptyIrq,
   output logic      errorIrq,
   output logic      txDoneIrq,
   output logic      dataOut,
   output logic      dataOe,
   output logic      cardClk
);
   import scp_pkg::*;

   typedef enum logic [1:0] {L_IDLE, L_RX, L_TX} scp_link_t;

   // ------------------------------------------------------------
   // link reset and crossings into the link domain
   // ------------------------------------------------------------
   logic [1:0] lRst_q;
   logic       linkRstn;
   logic [8:0] cfgS1_q;
   logic [8:0] cfgS2_q;
   logic [1:0] lineS_q;
   logic [1:0] reqS_q;
   logic       reqTgl_q;
   logic [7:0] txDataReg_q;

   always_ff @(posedge linkClk or negedge resetn) begin
      if (!resetn) begin
         lRst_q <= 2'b00;
      end else begin
         lRst_q <= {lRst_q[0], 1'b1};
      end
   end
   assign linkRstn = lRst_q[1];

   always_ff @(posedge linkClk or negedge linkRstn) begin
      if (!linkRstn) begin
         cfgS1_q <= 9'h0_00;
         cfgS2_q <= 9'h0_00;
         lineS_q <= 2'b11;
         reqS_q  <= 2'b00;
      end else begin
         cfgS1_q <= {cardModeEnable, rxEnBit, txEnBit, bitOrderBit, dataInvertBit,
                     oddParity, clockFixMode, clockLevelSelect, clockOutputEnable};
         cfgS2_q <= cfgS1_q;
         lineS_q <= {lineS_q[0], dataIn};
         reqS_q  <= {reqS_q[0], reqTgl_q};
      end
   end

   logic cModeL, cRxEn, cTxEn, cMsb, cInv, cOdd, cFix, cLvl, cClkEn;
   assign {cModeL, cRxEn, cTxEn, cMsb, cInv, cOdd, cFix, cLvl, cClkEn} = cfgS2_q;

   // ------------------------------------------------------------
   // card clock and base tick
   // ------------------------------------------------------------
   logic baseTick;

   scp_card_clock u_clk (
      .linkClk   (linkClk),
      .linkRstn  (linkRstn),
      .runReq    (cModeL & cClkEn),
      .fixMode   (cFix),
      .holdLevel (cLvl),
      .baseTick  (baseTick),
      .cardClk   (cardClk)
   );

   // ------------------------------------------------------------
   // link engine
   // ------------------------------------------------------------
   scp_link_t  lState_q;
   logic [8:0] cnt_q;
   logic [3:0] bitIdx_q;
   logic       linePrev_q;
   logic [7:0] rxShift_q;
   logic [7:0] rxByte_q;
   logic       rxErr_q;
   logic       rxDoneTgl_q;
   logic       txDoneTgl_q;
   logic       txErsTgl_q;
   logic       txAck_q;
   logic       txRetry_q;
   logic [9:0] txFrame_q;
   logic       rxLine;
   logic       bitEnd;
   logic       atSample;

   assign rxLine   = lineS_q[1];
   assign bitEnd   = baseTick && (cnt_q == CNT_LAST);
   assign atSample = baseTick && (cnt_q == CNT_SAMPLE);

   always_ff @(posedge linkClk or negedge linkRstn) begin
      if (!linkRstn) begin
         linePrev_q <= 1'b1;
      end else if (baseTick) begin
         linePrev_q <= rxLine;
      end
   end

   always_ff @(posedge linkClk or negedge linkRstn) begin
      if (!linkRstn) begin
         lState_q    <= L_IDLE;
         cnt_q       <= 9'h0_00;
         bitIdx_q    <= BIT_START;
         rxShift_q   <= 8'h00;
         rxByte_q    <= RX_DATA_RST;
         rxErr_q     <= 1'b0;
         rxDoneTgl_q <= 1'b0;
         txDoneTgl_q <= 1'b0;
         txErsTgl_q  <= 1'b0;
         txAck_q     <= 1'b0;
         txRetry_q   <= 1'b0;
         txFrame_q   <= 10'h3_FF;
         dataOut     <= 1'b1;
         dataOe      <= 1'b0;
      end else if (baseTick) begin
         cnt_q <= bitEnd ? 9'h0_00 : cnt_q + 9'h0_01;
         if (bitEnd) begin
            bitIdx_q <= bitIdx_q + 4'h1;
         end
         case (lState_q)
            L_IDLE: begin
               dataOe   <= 1'b0;
               cnt_q    <= 9'h0_00;
               bitIdx_q <= BIT_START;
               if (cModeL && cTxEn && (reqS_q[1] != txAck_q)) begin
                  // character frame only; no block transfer mode
                  txFrame_q <= {line_parity(map_bits(txDataReg_q, cMsb, cInv), cOdd),
                                map_bits(txDataReg_q, cMsb, cInv), 1'b0};
                  lState_q  <= L_TX;
               end else if (cModeL && cRxEn && linePrev_q && !rxLine) begin
                  cnt_q    <= 9'h0_01;
                  rxErr_q  <= 1'b0;
                  lState_q <= L_RX;
               end
            end
            L_RX: begin
               if (atSample) begin
                  if (bitIdx_q == BIT_START && rxLine) begin
                     lState_q <= L_IDLE; // glitch, not a start bit
                  end else if (bitIdx_q > BIT_START && bitIdx_q < BIT_PARITY) begin
                     rxShift_q[3'(bitIdx_q - 4'h1)] <= rxLine;
                  end else if (bitIdx_q == BIT_PARITY) begin
                     rxErr_q     <= line_parity(rxShift_q, cOdd) != rxLine;
                     rxByte_q    <= map_bits(rxShift_q, cMsb, cInv);
                     rxDoneTgl_q <= ~rxDoneTgl_q;
                  end else if (bitIdx_q == BIT_ERR_SLOT && rxErr_q) begin
                     dataOut <= 1'b0;
                     dataOe  <= 1'b1;
                  end else if (bitIdx_q == BIT_ERR_CHECK) begin
                     dataOe <= 1'b0;
                  end
               end
               if (bitEnd && bitIdx_q == BIT_ERR_CHECK) begin
                  lState_q <= L_IDLE;
               end
            end
            L_TX: begin
               if (cnt_q == 9'h0_00) begin
                  if (bitIdx_q <= BIT_PARITY) begin
                     dataOut <= txFrame_q[bitIdx_q];
                     dataOe  <= 1'b1;
                  end else begin
                     dataOut <= 1'b1;
                     dataOe  <= 1'b0;
                  end
                  if (bitIdx_q == BIT_ERR_CHECK) begin
                     txRetry_q <= !rxLine;
                     if (!rxLine) begin
                        txErsTgl_q <= ~txErsTgl_q;
                     end else begin
                        txDoneTgl_q <= ~txDoneTgl_q;
                        txAck_q     <= ~txAck_q;
                     end
                  end
               end
               if (bitEnd && bitIdx_q == BIT_ERR_CHECK && !txRetry_q) begin
                  lState_q <= L_IDLE;
               end else if (bitEnd && bitIdx_q == BIT_RETRY_END) begin
                  bitIdx_q <= BIT_START;
               end
            end
            default: begin
               lState_q <= L_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // events into the cpu domain
   // ------------------------------------------------------------
   logic [2:0] evS1_q;
   logic [2:0] evS2_q;
   logic [2:0] evS3_q;
   logic       rxEv;
   logic       txDoneEv;
   logic       ersEv;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         evS1_q <= 3'h0;
         evS2_q <= 3'h0;
         evS3_q <= 3'h0;
      end else begin
         evS1_q <= {rxDoneTgl_q, txDoneTgl_q, txErsTgl_q};
         evS2_q <= evS1_q;
         evS3_q <= evS2_q;
      end
   end
   assign {rxEv, txDoneEv, ersEv} = evS2_q ^ evS3_q;

   // ------------------------------------------------------------
   // transmit request and status flags
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reqTgl_q    <= 1'b0;
         txDataReg_q <= 8'h00;
      end else if (txWrite) begin
         reqTgl_q    <= ~reqTgl_q;
         txDataReg_q <= txData;
      end
   end

   logic rxFull_d, parErr_d, ovr_d, ers_d, txEnd_d, txEmpty_d;

   // sets win over clears in the same cycle
   always_comb begin
      rxFull_d  = rxFullFlag & ~clrRxFull;
      parErr_d  = parityErrFlag & ~clrParityErr;
      ovr_d     = overrunErrorFlag & ~clrOverrun;
      ers_d     = errorSignalFlag & ~clrErrSignal;
      txEnd_d   = txEndFlag & ~txWrite;
      txEmpty_d = txEmptyFlag & ~txWrite;
      if (rxEv && rxFullFlag) begin
         ovr_d = 1'b1;
      end else if (rxEv && rxErr_q) begin
         parErr_d = 1'b1;
      end else if (rxEv) begin
         rxFull_d = 1'b1;
      end
      if (ersEv) begin
         ers_d = 1'b1;
      end
      if (txDoneEv) begin
         txEnd_d   = 1'b1;
         txEmpty_d = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rxFullFlag       <= 1'b0;
         parityErrFlag    <= 1'b0;
         overrunErrorFlag <= 1'b0;
         errorSignalFlag  <= 1'b0;
         txEndFlag        <= TX_END_RST;
         txEmptyFlag      <= TX_EMPTY_RST;
      end else begin
         rxFullFlag       <= rxFull_d;
         parityErrFlag    <= parErr_d;
         overrunErrorFlag <= ovr_d;
         errorSignalFlag  <= ers_d;
         txEndFlag        <= txEnd_d;
         txEmptyFlag      <= txEmpty_d;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rxData <= RX_DATA_RST;
      end else if (rxEv && !rxFullFlag) begin
         rxData <= rxByte_q;
      end
   end

   // ------------------------------------------------------------
   // interrupt requests
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rxFullIrq  <= 1'b0;
         txEmptyIrq <= 1'b0;
         errorIrq   <= 1'b0;
         txDoneIrq  <= 1'b0;
      end else begin
         rxFullIrq  <= rxFull_d & rxIrqEnable;
         txEmptyIrq <= txEnd_d & txIrqEnable;
         errorIrq   <= (ovr_d | parErr_d | ers_d) & rxIrqEnable;
         txDoneIrq  <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   property p_rx_irq;
      @(posedge clk) disable iff (!resetn)
      (rxFullFlag && rxIrqEnable && $stable(rxIrqEnable)) |-> rxFullIrq;
   endproperty
   a_rx_irq: assert property (p_rx_irq) else $error("rx irq missing");

   property p_err_irq;
      @(posedge clk) disable iff (!resetn)
      errorIrq |-> (overrunErrorFlag || parityErrFlag || errorSignalFlag);
   endproperty
   a_err_irq: assert property (p_err_irq) else $error("error irq without flag");

   property p_tx_irq;
      @(posedge clk) disable iff (!resetn)
      txEmptyIrq |-> (txEndFlag && $past(txIrqEnable));
   endproperty
   a_tx_irq: assert property (p_tx_irq) else $error("tx irq without end flag");

   property p_no_tei;
      @(posedge clk) disable iff (!resetn)
      !txDoneIrq;
   endproperty
   a_no_tei: assert property (p_no_tei) else $error("tx done irq raised");

   property p_par_keep;
      @(posedge clk) disable iff (!resetn)
      (rxEv && rxErr_q && !rxFullFlag && !clrParityErr) |=>
         (parityErrFlag && !rxFullFlag && rxData == $past(rxByte_q));
   endproperty
   a_par_keep: assert property (p_par_keep) else $error("parity error handling wrong");

   property p_ers_end;
      @(posedge clk) disable iff (!resetn)
      (ersEv && !txWrite) |=> (errorSignalFlag && txEndFlag == $past(txEndFlag));
   endproperty
   a_ers_end: assert property (p_ers_end) else $error("error signal flag wrong");

   property p_sample_pt;
      @(posedge linkClk) disable iff (!linkRstn)
      (lState_q == L_RX && bitIdx_q == BIT_PARITY && atSample) |=>
         (rxDoneTgl_q != $past(rxDoneTgl_q));
   endproperty
   a_sample_pt: assert property (p_sample_pt) else $error("parity not sampled");

   property p_slot_free;
      @(posedge linkClk) disable iff (!linkRstn)
      (lState_q == L_RX && !rxErr_q && bitIdx_q > BIT_PARITY) |-> !dataOe;
   endproperty
   a_slot_free: assert property (p_slot_free) else $error("line driven after good rx");

   property p_err_drive;
      @(posedge linkClk) disable iff (!linkRstn)
      (lState_q == L_RX && rxErr_q && bitIdx_q == BIT_ERR_SLOT && cnt_q > CNT_SAMPLE)
         |-> (dataOe && !dataOut);
   endproperty
   a_err_drive: assert property (p_err_drive) else $error("error signal not driven");

   c_rx_ok:  cover property (@(posedge clk) disable iff (!resetn) rxEv && !rxErr_q);
   c_rx_par: cover property (@(posedge clk) disable iff (!resetn) rxEv && rxErr_q);
   c_tx_ers: cover property (@(posedge clk) disable iff (!resetn) ersEv);
   c_tx_end: cover property (@(posedge clk) disable iff (!resetn) txDoneEv);

endmodule

// ### scp_card_model.sv
/* card side of the half-duplex data line: sends frames, watches frames,
   answers with an error signal on request.
   assumes a pull-up on the line and linkClk at twice the base clock. */
module scp_card_model (
   input  wire logic linkClk,
   input  wire logic dataOut,
   input  wire logic dataOe,
   output logic      line
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // line and state
   // ------------------------------------------------------------
   localparam int ETU = 744;
   logic       cardOe  = 1'b0;
   logic       cardOut = 1'b1;
   logic       busy    = 1'b0;
   int         nakLeft = 0;
   logic [8:0] seen[$];
   logic [9:0] v;
   // pull-up: a released line reads high
   assign line = ((dataOe && !dataOut) || (cardOe && !cardOut)) ? 1'b0 : 1'b1;

   // ------------------------------------------------------------
   // card sends one frame, reports an error signal seen at 11 etu
   // ------------------------------------------------------------
   task automatic send_frame(input logic [8:0] b, output logic nak);
      @(posedge linkClk);
      busy = 1'b1;
      cardOe <= 1'b1;
      cardOut <= 1'b0;
      repeat (ETU) @(posedge linkClk);
      for (int i = 0; i < 9; i++) begin
         cardOut <= b[i];
         repeat (ETU) @(posedge linkClk);
      end
      cardOe <= 1'b0;
      repeat (ETU) @(posedge linkClk);
      nak = !line;
      repeat (ETU) @(posedge linkClk);
      busy = 1'b0;
   endtask

   // ------------------------------------------------------------
   // card receives: mid-bit sampling, error signal when asked
   // ------------------------------------------------------------
   always begin
      @(negedge line);
      if (!busy) begin
         repeat (ETU / 2) @(posedge linkClk);
         for (int i = 0; i < 10; i++) begin
            v[i] = line;
            if (i < 9) begin
               repeat (ETU) @(posedge linkClk);
            end
         end
         repeat (ETU) @(posedge linkClk);
         if (nakLeft > 0) begin
            // low for a full etu so the sender sees it at 11 etu
            nakLeft--;
            cardOe <= 1'b1;
            cardOut <= 1'b0;
         end
         repeat (ETU) @(posedge linkClk);
         cardOe <= 1'b0;
         repeat (ETU / 2) @(posedge linkClk);
         seen.push_back(v[9:1]);
      end
   end
endmodule

// ### testbench.sv
/* bench for the card serial port: random bytes both ways, parity
   errors, error signals with retransmission, overrun, card clock stop.
   assumes the card model on the far side of the data line. */
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic       clk = 1'b0, linkClk = 1'b0, resetn = 1'b0;
   logic       cardModeEnable = 1'b1, rxEnBit = 1'b1, txEnBit = 1'b0;
   logic       rxIrqEnable = 1'b0, txIrqEnable = 1'b0, bitOrderBit = 1'b0;
   logic       dataInvertBit = 1'b0, oddParity = 1'b0, clockFixMode = 1'b0;
   logic       clockLevelSelect = 1'b0, clockOutputEnable = 1'b1, txWrite = 1'b0;
   logic       clrRxFull = 1'b0, clrParityErr = 1'b0, clrOverrun = 1'b0;
   logic       clrErrSignal = 1'b0;
   logic [7:0] txData = 8'h00, rxData, d;
   logic       rxFullFlag, parityErrFlag, overrunErrorFlag, errorSignalFlag;
   logic       txEndFlag, txEmptyFlag, rxFullIrq, txEmptyIrq, errorIrq, txDoneIrq;
   logic       dataOut, dataOe, cardClk, line, nak, msb, odd, ien;
   logic [4:0] flags;
   int         err_count = 0, total_checks = 0;

   assign flags = {txEndFlag, errorSignalFlag, overrunErrorFlag, parityErrFlag, rxFullFlag};
   always #50 clk = ~clk;
   initial begin
      #7;
      forever #24 linkClk = ~linkClk;
   end

   scp_serial_port i_dut (.clk, .resetn, .linkClk, .cardModeEnable, .rxEnBit, .txEnBit,
      .rxIrqEnable, .txIrqEnable, .bitOrderBit, .dataInvertBit, .oddParity, .clockFixMode,
      .clockLevelSelect, .clockOutputEnable, .txData, .txWrite, .clrRxFull, .clrParityErr,
      .clrOverrun, .clrErrSignal, .dataIn(line), .rxData, .rxFullFlag, .parityErrFlag,
      .overrunErrorFlag, .errorSignalFlag, .txEndFlag, .txEmptyFlag, .rxFullIrq,
      .txEmptyIrq, .errorIrq, .txDoneIrq, .dataOut, .dataOe, .cardClk);
   scp_card_model i_card (.linkClk, .dataOut, .dataOe, .line);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("checks %0d, mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // line bits of a byte: both convention bits follow m
   function automatic logic [8:0] to_line(input logic [7:0] x, input logic m,
                                          input logic o);
      logic [8:0] b;
      for (int i = 0; i < 8; i++) begin
         b[i] = (m ? x[7 - i] : x[i]) ^ m;
      end
      b[8] = ^b[7:0] ^ o;
      return b;
   endfunction

   task automatic wait_flag(input int idx, input int lim);
      int n;
      n = 0;
      while (flags[idx] !== 1'b1 && n < lim) begin
         @(posedge clk);
         n++;
      end
      if (n == lim) begin
         err_count++;
         final_report();
      end
      @(posedge clk);
   endtask

   // controls change only between frames
   task automatic cfg();
      @(posedge clk);
      d = 8'($urandom);
      msb = 1'($urandom);
      odd = 1'($urandom);
      ien = 1'($urandom);
      bitOrderBit <= msb;
      dataInvertBit <= msb;
      oddParity <= odd;
      rxIrqEnable <= ien;
      txIrqEnable <= !ien;
      repeat (3) @(posedge clk);
   endtask

   task automatic pulse_clear(input logic [3:0] m);
      @(posedge clk);
      {clrErrSignal, clrOverrun, clrParityErr, clrRxFull} <= m;
      @(posedge clk);
      {clrErrSignal, clrOverrun, clrParityErr, clrRxFull} <= 4'h0;
      @(posedge clk);
      check(9'(flags[3:0] & m), 9'h000);
   endtask

   task automatic rx_case(input logic bad);
      cfg();
      i_card.send_frame(to_line(d, msb, odd) ^ {bad, 8'h00}, nak);
      check(9'(nak), 9'(bad));
      wait_flag(bad ? 1 : 0, 300);
      check(9'(rxData), 9'(d));
      check(9'(rxFullFlag), 9'(!bad));
      check(9'(rxFullIrq), 9'(!bad && ien));
      check(9'(errorIrq), 9'(bad && ien));
      pulse_clear(4'b0011);
   endtask

   task automatic clk_rises(input int exp);
      int   r;
      logic p;
      r = 0;
      @(posedge linkClk);
      p = cardClk;
      repeat (40) begin
         @(posedge linkClk);
         r += int'(cardClk && !p);
         p = cardClk;
      end
      check(9'(r), 9'(exp));
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(20));
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      check(9'({txEmptyFlag, rxData}), 9'h100);
      check(9'(txEndFlag), 9'h001);
      for (int i = 0; i < 4; i++) begin
         rx_case(i[0]);
      end
      // overrun: second byte arrives before the first is taken
      cfg();
      i_card.send_frame(to_line(d & 8'h7F, msb, odd), nak);
      // receiver leaves its frame a few ticks after 12 etu; a start bit sooner is missed
      repeat (10) @(posedge clk);
      i_card.send_frame(to_line(8'hFF, msb, odd), nak);
      wait_flag(2, 300);
      check(9'(rxData), 9'(d & 8'h7F));
      check(9'(errorIrq), 9'(ien));
      pulse_clear(4'b0111);
      @(posedge clk);
      rxEnBit <= 1'b0;
      txEnBit <= 1'b1;
      for (int n = 0; n < 3; n++) begin
         cfg();
         i_card.nakLeft = n;
         i_card.seen.delete();
         txData <= d;
         txWrite <= 1'b1;
         @(posedge clk);
         txWrite <= 1'b0;
         repeat (2) @(posedge clk);
         check(9'(txEndFlag), 9'h000);
         wait_flag(4, 20000);
         // end flag rises at 11 etu, the card logs the frame only at 12 etu
         repeat (400) @(posedge clk);
         check(9'(i_card.seen.size()), 9'(n + 1));
         foreach (i_card.seen[k]) begin
            check(i_card.seen[k], to_line(d, msb, odd));
         end
         check(9'(errorSignalFlag), 9'(n > 0));
         check(9'(errorIrq), 9'(n > 0 && ien));
         check(9'({txEmptyIrq, txDoneIrq}), 9'({!ien, 1'b0}));
         pulse_clear(4'b1000);
      end
      for (int lvl = 0; lvl < 2; lvl++) begin
         clk_rises(20);
         @(posedge clk);
         clockFixMode <= 1'b1;
         clockLevelSelect <= 1'(lvl);
         clockOutputEnable <= 1'b0;
         repeat (5) @(posedge clk);
         clk_rises(0);
         check(9'(cardClk), 9'(lvl));
         @(posedge clk);
         clockOutputEnable <= 1'b1;
         repeat (5) @(posedge clk);
      end
      clk_rises(20);
      final_report();
   end
endmodule
